// ===== rtl/srp_port.sv
// serial register access port: link shifter, crossing and register bank
module srp_port
    import srp_pkg::*;
#(
    parameter int NUM_REGS = REG_CNT
)
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic mosi_i,
    input wire logic [AUX_W-1:0] aux_adc_i,
    output logic miso_o,
    output logic miso_oe_n,
    output logic frame_seen_o
);

    // ------------------------------------------------------------
    // link side, serial clock domain
    // ------------------------------------------------------------
    logic [CNT_W-1:0] bit_cnt_r;
    logic [REG_W-1:0] shift_r;
    logic [IDX_W-1:0] out_idx_r;
    srp_cmd_t cmd_hold_r;
    logic frame_tgl_r;
    logic [REG_W-1:0] rd_word_r;

    // count and shift on rising edges; chip select high clears both,
    // so a short frame simply vanishes
    always_ff @(posedge sclk_i or posedge cs_n_i)
    begin
        if (cs_n_i)
        begin
            bit_cnt_r <= CNT_ZERO;
            shift_r <= REG_RST;
        end
        else
        begin
            shift_r <= {shift_r[REG_W-2:0], mosi_i};
            if (bit_cnt_r != CNT_DONE)
            begin
                bit_cnt_r <= bit_cnt_r + CNT_ONE;
            end
        end
    end

    // the finished command survives chip select; reset is the only clear
    always_ff @(posedge sclk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cmd_hold_r <= '0;
            frame_tgl_r <= 1'b0;
        end
        else if (!cs_n_i && bit_cnt_r == CNT_LAST)
        begin
            cmd_hold_r <= {shift_r[REG_W-2:0], mosi_i};
            frame_tgl_r <= ~frame_tgl_r;
        end
    end

    // output bit index moves on falling edges; it copies the count of
    // rising edges, so the leading falling edge of mode 3 leaves bit 15
    always_ff @(negedge sclk_i or posedge cs_n_i)
    begin
        if (cs_n_i)
        begin
            out_idx_r <= '0;
        end
        else
        begin
            out_idx_r <= bit_cnt_r[IDX_W-1:0];
        end
    end

    // msb first, upper byte before lower; bit 15 shows at chip select
    // fall because no clock edge exists yet to launch it
    always_comb
    begin
        miso_o = rd_word_r[REG_W-1-out_idx_r];
        miso_oe_n = cs_n_i;
    end

    // ------------------------------------------------------------
    // crossing: toggle in, command word held stable meanwhile
    // ------------------------------------------------------------
    logic tgl_meta_r;
    logic tgl_sync_r;
    logic tgl_prev_r;
    logic frame_evt;

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            tgl_meta_r <= 1'b0;
            tgl_sync_r <= 1'b0;
            tgl_prev_r <= 1'b0;
        end
        else
        begin
            tgl_meta_r <= frame_tgl_r;
            tgl_sync_r <= tgl_meta_r;
            tgl_prev_r <= tgl_sync_r;
        end
    end

    // the held word is only read a few core cycles after the toggle;
    // the next frame needs 16 slow clocks before it can change it
    assign frame_evt = tgl_sync_r ^ tgl_prev_r;

    // ------------------------------------------------------------
    // register bank and command execution, core domain
    // ------------------------------------------------------------
    logic [REG_W-1:0] bank_r [NUM_REGS];
    logic [REG_W-1:0] aux_r;
    srp_addr_t cmd_addr;
    logic do_write;
    logic do_read;

    assign cmd_addr = cmd_hold_r.addr;
    assign do_write = frame_evt && cmd_hold_r.wr;
    assign do_read = frame_evt && !cmd_hold_r.wr && !cmd_hold_r.pad;

    // converter result, zero-extended, straight binary
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            aux_r <= REG_RST;
        end
        else
        begin
            aux_r <= {AUX_PAD, aux_adc_i};
        end
    end

    // one byte per write frame; the data byte lands in the half chosen
    // by the address lsb, the other half is left alone
    genvar gi;
    generate
        for (gi = 0; gi < NUM_REGS; gi++)
        begin : g_reg
            always_ff @(posedge core_clk)
            begin
                if (!rst_n)
                begin
                    bank_r[gi] <= REG_RST;
                end
                else if (do_write && cmd_addr.idx == gi[REG_IDX_W-1:0])
                begin
                    if (cmd_addr.upper)
                    begin
                        bank_r[gi][REG_W-1:BYTE_W] <= cmd_hold_r.data;
                    end
                    else
                    begin
                        bank_r[gi][BYTE_W-1:0] <= cmd_hold_r.data;
                    end
                end
            end
        end
    endgenerate

    // read result waits here for the next frame; the trailing byte of a
    // read command is never looked at
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            rd_word_r <= REG_RST;
        end
        else if (do_read)
        begin
            if (cmd_addr.idx == AUX_REG_IDX)
            begin
                rd_word_r <= aux_r;
            end
            else
            begin
                rd_word_r <= bank_r[cmd_addr.idx];
            end
        end
    end

    // status flag: one core cycle per completed frame
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            frame_seen_o <= 1'b0;
        end
        else
        begin
            frame_seen_o <= frame_evt;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_float_when_idle;
        @(posedge core_clk) disable iff (!rst_n)
        cs_n_i |-> miso_oe_n;
    endproperty
    a_float_when_idle: assert property (p_float_when_idle)
        else $error("data output driven while deselected");

    property p_idle_count;
        @(posedge core_clk) disable iff (!rst_n)
        cs_n_i |-> bit_cnt_r == CNT_ZERO;
    endproperty
    a_idle_count: assert property (p_idle_count)
        else $error("frame counter moved while deselected");

    property p_frame_len;
        @(posedge sclk_i) disable iff (!rst_n)
        $changed(frame_tgl_r) |-> $past(bit_cnt_r) == CNT_LAST;
    endproperty
    a_frame_len: assert property (p_frame_len)
        else $error("command taken at the wrong bit count");

    property p_last_bit;
        @(posedge sclk_i) disable iff (!rst_n)
        (!cs_n_i && bit_cnt_r == CNT_LAST) |=> cmd_hold_r.data[0] == $past(mosi_i);
    endproperty
    a_last_bit: assert property (p_last_bit)
        else $error("last input bit not in the command lsb");

    property p_out_follows;
        @(posedge sclk_i) disable iff (!rst_n)
        !cs_n_i |-> out_idx_r == bit_cnt_r[IDX_W-1:0];
    endproperty
    a_out_follows: assert property (p_out_follows)
        else $error("output bit index out of step with input");

    property p_write_byte;
        @(posedge core_clk) disable iff (!rst_n)
        (do_write && cmd_addr.upper) |=>
            bank_r[$past(cmd_addr.idx)][REG_W-1:BYTE_W] == $past(cmd_hold_r.data)
            && bank_r[$past(cmd_addr.idx)][BYTE_W-1:0]
               == $past(bank_r[cmd_addr.idx][BYTE_W-1:0]);
    endproperty
    a_write_byte: assert property (p_write_byte)
        else $error("upper byte write disturbed register");

    property p_read_whole;
        @(posedge core_clk) disable iff (!rst_n)
        (do_read && cmd_addr.idx != AUX_REG_IDX) |=>
            rd_word_r == $past(bank_r[cmd_addr.idx]);
    endproperty
    a_read_whole: assert property (p_read_whole)
        else $error("read did not return the full register");

    property p_aux_read;
        @(posedge core_clk) disable iff (!rst_n)
        (do_read && cmd_addr.idx == AUX_REG_IDX) |=>
            rd_word_r[REG_W-1:AUX_W] == AUX_PAD;
    endproperty
    a_aux_read: assert property (p_aux_read)
        else $error("converter register has bits above 12");

    property p_read_ready;
        @(posedge core_clk) disable iff (!rst_n)
        $changed(frame_tgl_r) |-> ##[2:4] frame_evt;
    endproperty
    a_read_ready: assert property (p_read_ready)
        else $error("frame not seen by core in time");

endmodule : srp_port

// ===== rtl/srp_pkg.sv
// constants and types for the serial register access port
package srp_pkg;

    // ------------------------------------------------------------
    // frame and register geometry
    // ------------------------------------------------------------
    localparam int FRAME_BITS = 16;
    localparam int CNT_W = 5;
    localparam int IDX_W = 4;
    localparam int ADDR_W = 6;
    localparam int REG_W = 16;
    localparam int BYTE_W = 8;
    localparam int REG_IDX_W = ADDR_W - 1;
    localparam int REG_CNT = 1 << REG_IDX_W;
    localparam int AUX_W = 12;

    localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
    localparam logic [CNT_W-1:0] CNT_LAST = 5'h0F;
    localparam logic [CNT_W-1:0] CNT_DONE = 5'h10;

    // ------------------------------------------------------------
    // register map and reset values
    // ------------------------------------------------------------
    localparam logic [REG_IDX_W-1:0] AUX_REG_IDX = 5'h04;
    localparam logic [REG_W-1:0] REG_RST = 16'h0000;
    localparam logic [REG_W-AUX_W-1:0] AUX_PAD = 4'h0;

    // ------------------------------------------------------------
    // command word as it arrives, first bit in bit 15
    // ------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic pad;
        logic [ADDR_W-1:0] addr;
        logic [BYTE_W-1:0] data;
    } srp_cmd_t;

    // byte address split: register index and byte select
    typedef struct packed {
        logic [REG_IDX_W-1:0] idx;
        logic upper;
    } srp_addr_t;

endpackage : srp_pkg

// ===== tb/srp_host_model.sv
// host model: serial bus master sending frames of up to 16 clocks
module srp_host_model
(
    output logic sclk,
    output logic cs_n,
    output logic mosi,
    input wire logic miso
);
    timeunit 1ns;
    timeprecision 100ps;

    // ----
    // frame engine, clock stands still outside frames
    // ----
    initial
    begin
        sclk = 1'b1;
        cs_n = 1'b1;
        mosi = 1'b0;
    end

    // n below 16 ends the frame early on purpose
    task automatic frame(input logic [15:0] cmd, input int n,
        output logic [15:0] rx);
        begin
            rx = 16'h0000;
            #23 cs_n = 1'b0;
            for (int i = 15; i >= 16 - n; i--)
            begin
                #30 sclk = 1'b0;
                mosi = cmd[i];
                #80 sclk = 1'b1;
                rx[i] = miso;
                #50;
            end
            cs_n = 1'b1;
            // no pull on the line: show the inverse once released
            mosi = ~mosi;
            #160;
        end
    endtask : frame
endmodule : srp_host_model

// ===== tb/serial_register_access_port_tb.sv
// testbench for the serial register access port
module serial_register_access_port_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import srp_pkg::*;

    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [AUX_W-1:0] aux_adc = 12'h000;
    logic sclk, cs_n, mosi, miso_o, miso_oe_n, frame_seen;
    logic [15:0] rx;
    wire miso_w;
    int mismatches = 0;
    int cmp_count = 0;
    int cycles = 0;
    int seen = 0;

    // the bench resolves the data line from the enable
    assign miso_w = miso_oe_n ? 1'bz : miso_o;

    srp_port dut (.core_clk(core_clk), .rst_n(rst_n), .sclk_i(sclk),
        .cs_n_i(cs_n), .mosi_i(mosi), .aux_adc_i(aux_adc),
        .miso_o(miso_o), .miso_oe_n(miso_oe_n),
        .frame_seen_o(frame_seen));
    srp_host_model host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi),
        .miso(miso_w));

    // ----
    // clock, watchdog and closing
    // ----
    initial
    begin
        forever #5 core_clk = ~core_clk;
    end

    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (frame_seen === 1'b1)
            seen <= seen + 1;
        if (cycles == 20000)
        begin
            mismatches++;
            complete_run();
        end
    end

    task automatic complete_run;
        begin
            $display("mismatches %0d compares %0d", mismatches, cmp_count);
            if (mismatches == 0 && cmp_count > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask : complete_run

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        begin
            cmp_count++;
            if (got !== exp)
            begin
                mismatches++;
                $display("mismatch at %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask : chk

    // ----
    // scenarios
    // ----
    task automatic t_reset_word;
        begin
            host.frame(16'h83AB, 16, rx);
            chk(rx, 16'h0000);
            chk({15'h0000, miso_oe_n}, 16'h0001);
        end
    endtask : t_reset_word

    task automatic t_full_reg;
        begin
            host.frame(16'h82CD, 16, rx);
            host.frame(16'h02FF, 16, rx);
            host.frame(16'h0300, 16, rx);
            chk(rx, 16'hABCD);
            host.frame(16'h8577, 16, rx);
            chk(rx, 16'hABCD);
        end
    endtask : t_full_reg

    task automatic t_one_byte;
        begin
            host.frame(16'h0400, 16, rx);
            host.frame(16'h0900, 16, rx);
            chk(rx, 16'h7700);
        end
    endtask : t_one_byte

    task automatic t_aux;
        begin
            @(negedge core_clk);
            aux_adc = 12'hA5C;
            host.frame(16'h0900, 16, rx);
            host.frame(16'h0200, 16, rx);
            chk(rx, 16'h0A5C);
        end
    endtask : t_aux

    // write cut short after ten clocks must leave the byte alone
    task automatic t_partial;
        begin
            host.frame(16'h8311, 10, rx);
            host.frame(16'h0200, 16, rx);
            host.frame(16'h0000, 16, rx);
            chk(rx, 16'hABCD);
        end
    endtask : t_partial

    task automatic t_rereset;
        begin
            @(negedge core_clk);
            rst_n = 1'b0;
            repeat (2) @(negedge core_clk);
            rst_n = 1'b1;
            repeat (3) @(negedge core_clk);
            host.frame(16'h0300, 16, rx);
            chk(rx, 16'h0000);
            host.frame(16'h0000, 16, rx);
            chk(rx, 16'h0000);
            chk(seen[15:0], 16'h000D);
        end
    endtask : t_rereset

    initial
    begin
        repeat (2) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (3) @(negedge core_clk);
        t_reset_word();
        t_full_reg();
        t_one_byte();
        t_aux();
        t_partial();
        t_rereset();
        complete_run();
    end
endmodule : serial_register_access_port_tb
